/* dtp_top.sv */
// Purpose: dual 8-bit timer / pwm with 16-bit cascade, avalon-mm slave
// Assumes: single 250 MHz clock, synchronous active-high reset
// Notes:   counters are readable through a status word for observability
// Functional notes
// (RQ1) software keeps pwm off when used as timer
// (RQ2) pwm control: cascade, ch2 enable, ch1 enable
// (RQ3) timer control: enables and two prescale fields
// (RQ4) timer setup order: period, irq, prescale, enable
// (RQ5) cascade merges channels into one 16-bit pwm
// (RQ6) channel two supplies upper byte in cascade
// (RQ7) cascade uses prescaler one, upper counts on carry
// (RQ8) cascade uses channel-one flag and output
// (RQ9) period match: clear, set output, latch, flag
// (RQ10) duty match drives low; duty latched at wrap
// (RQ11) eight prescale ratios, cleared by reset
// (RQ12) timers halt in sleep unless conversion runs
// (RQ13) cascade compares full 16-bit values
`timescale 1ns/1ps
module dtp_top (
	input  wire logic                       core_clk_i,
	input  wire logic                       srst_i,
	input  wire logic [dtp_pkg::ADDR_W-1:0] avs_address_i,
	input  wire logic                       avs_read_i,
	input  wire logic                       avs_write_i,
	input  wire logic [31:0]                avs_writedata_i,
	input  wire logic [3:0]                 avs_byteenable_i,
	input  wire logic                       sleep_i,
	input  wire logic                       adc_busy_i,
	output logic [31:0]                     avs_readdata_o,
	output logic                            avs_waitrequest_o,
	output logic                            pwm_one_o,
	output logic                            pwm_two_o,
	output logic                            irq_o
);
	import dtp_pkg::*;

	typedef enum logic [1:0] {
		DTP_IDLE = 2'b01,
		DTP_DONE = 2'b10
	} dtp_bus_t;

	dtp_bus_t   bus_state;
	logic [7:0] pwm_channel_control;
	logic [7:0] timer_enable_prescale;
	logic [7:0] period_value_one;
	logic [7:0] period_value_two;
	logic [7:0] duty_buffer_one;
	logic [7:0] duty_buffer_two;
	logic [1:0] irq_status;
	logic [1:0] irq_enable;
	logic [7:0] counter_one;
	logic [7:0] counter_two;
	logic [7:0] duty_latch_one;
	logic [7:0] duty_latch_two;
	logic       raw_pwm_one;
	logic       raw_pwm_two;
	logic       wrap_one;
	logic       wrap_two;
	logic       tick_one;
	logic       tick_two;
	logic       run_ok;
	logic       cascade_select;
	logic       counter_one_enable;
	logic       counter_two_enable;
	logic       ch_tick_two;
	logic       hit_one;
	logic       hit_two;
	logic       dhit_one;
	logic       dhit_two;
	logic       dzero_one;
	logic       dzero_two;
	logic [1:0] irq_events;
	logic       wr_acc;
	logic       rd_acc;
	logic [7:0] next_count_one;
	logic [7:0] next_count_two;
	logic [7:0] next_upper;

	assign cascade_select     = pwm_channel_control[PC_CASCADE_BIT];
	assign counter_one_enable = timer_enable_prescale[TC_EN1_BIT];
	assign counter_two_enable = timer_enable_prescale[TC_EN2_BIT];
	// sleep halts counting unless a conversion is in flight
	assign run_ok = !sleep_i || adc_busy_i; // [RQ12]

	// reads launch data at the taking edge; writes land only at the answer edge,
	// the one where the master sees waitrequest low
	assign wr_acc = avs_write_i && (bus_state == DTP_DONE);
	assign rd_acc = avs_read_i && (bus_state == DTP_IDLE);

	// one-hot bus handshake; waitrequest is low only in the cycle after a taken request
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			bus_state <= DTP_IDLE;
		end else begin
			case (bus_state)
				DTP_IDLE: if (avs_read_i || avs_write_i) bus_state <= DTP_DONE;
				DTP_DONE: bus_state <= DTP_IDLE;
				default:  bus_state <= DTP_IDLE;
			endcase
		end
	end

	// registered waitrequest: low exactly in the answer cycle
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			avs_waitrequest_o <= 1'b1;
		end else begin
			avs_waitrequest_o <= !((avs_read_i || avs_write_i) && bus_state == DTP_IDLE);
		end
	end

	// control registers; upper pwm control bits are held at zero
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			pwm_channel_control   <= RST_PWM_CTRL;
			timer_enable_prescale <= RST_TMR_CTRL; // [RQ11]
		end else if (wr_acc && avs_byteenable_i[0]) begin
			if (avs_address_i == IDX_PWM_CTRL)
				pwm_channel_control <= avs_writedata_i[7:0] & PC_WRITE_MASK; // [RQ2]
			if (avs_address_i == IDX_TMR_CTRL)
				timer_enable_prescale <= avs_writedata_i[7:0]; // [RQ3]
		end
	end

	// period and duty buffers; duty may be written at any time
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			period_value_one <= RST_BYTE;
			period_value_two <= RST_BYTE;
			duty_buffer_one  <= RST_BYTE;
			duty_buffer_two  <= RST_BYTE;
		end else if (wr_acc && avs_byteenable_i[0]) begin
			case (avs_address_i)
				IDX_PERIOD_ONE: period_value_one <= avs_writedata_i[7:0];
				IDX_PERIOD_TWO: period_value_two <= avs_writedata_i[7:0];
				IDX_DUTY_ONE:   duty_buffer_one  <= avs_writedata_i[7:0]; // [RQ10]
				IDX_DUTY_TWO:   duty_buffer_two  <= avs_writedata_i[7:0];
				default:        ;
			endcase
		end
	end

	// prescalers; channel two's prescaler is ignored in cascade
	dtp_prescaler u_div_one (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.run_i      (counter_one_enable && run_ok),
		.div_sel_i  (timer_enable_prescale[TC_DIV1_LSB +: 3]), // [RQ11]
		.tick_o     (tick_one)
	);
	dtp_prescaler u_div_two (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.run_i      (counter_two_enable && run_ok && !cascade_select),
		.div_sel_i  (timer_enable_prescale[TC_DIV2_LSB +: 3]),
		.tick_o     (tick_two)
	);

	// count after the coming tick; the duty match looks ahead so that the pin
	// falls on the very tick that brings the count to the latched duty
	assign next_count_one = counter_one + 8'h01;
	assign next_count_two = counter_two + 8'h01;
	assign next_upper     = (counter_one == 8'hff) ? next_count_two : counter_two;

	// matches: 8-bit alone, full 16-bit concatenation in cascade
	always_comb begin
		if (cascade_select) begin
			hit_one   = {counter_two, counter_one} == {period_value_two, period_value_one}; // [RQ13] [RQ6]
			hit_two   = hit_one;
			dhit_one  = {duty_latch_two, duty_latch_one} == {next_upper, next_count_one}; // [RQ13]
			dhit_two  = dhit_one;
			dzero_one = {duty_buffer_two, duty_buffer_one} == 16'h0000;
			dzero_two = dzero_one;
		end else begin
			hit_one   = counter_one == period_value_one; // [RQ9]
			hit_two   = counter_two == period_value_two;
			dhit_one  = duty_latch_one == next_count_one; // [RQ10]
			dhit_two  = duty_latch_two == next_count_two;
			dzero_one = duty_buffer_one == 8'h00;
			dzero_two = duty_buffer_two == 8'h00;
		end
	end

	// upper byte counts on carry from the lower byte or on the 16-bit wrap
	assign ch_tick_two = cascade_select
		? (tick_one && (counter_one == 8'hff || hit_one)) // [RQ7] [RQ5]
		: tick_two;

	dtp_channel u_ch_one (
		.core_clk_i   (core_clk_i),
		.srst_i       (srst_i),
		.tick_i       (tick_one),
		.period_hit_i (hit_one),
		.duty_hit_i   (dhit_one),
		.duty_zero_i  (dzero_one),
		.pwm_en_i     (pwm_channel_control[PC_CH1_EN_BIT]),
		.duty_buf_i   (duty_buffer_one),
		.count_o      (counter_one),
		.duty_latch_o (duty_latch_one),
		.pwm_o        (raw_pwm_one),
		.wrap_o       (wrap_one)
	);
	dtp_channel u_ch_two (
		.core_clk_i   (core_clk_i),
		.srst_i       (srst_i),
		.tick_i       (ch_tick_two),
		.period_hit_i (hit_two),
		.duty_hit_i   (dhit_two),
		.duty_zero_i  (dzero_two),
		.pwm_en_i     (pwm_channel_control[PC_CH2_EN_BIT] && !cascade_select),
		.duty_buf_i   (duty_buffer_two),
		.count_o      (counter_two),
		.duty_latch_o (duty_latch_two),
		.pwm_o        (raw_pwm_two),
		.wrap_o       (wrap_two)
	);

	// pins registered once more; in cascade only channel one speaks
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			pwm_one_o <= 1'b0;
			pwm_two_o <= 1'b0;
		end else begin
			pwm_one_o <= raw_pwm_one; // [RQ8]
			pwm_two_o <= raw_pwm_two && !cascade_select;
		end
	end

	// channel two flag is silent in cascade, flag one covers both bytes
	assign irq_events = {wrap_two && !cascade_select, wrap_one}; // [RQ8] [RQ9]

	// sticky status, set wins over write-one-to-clear
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			irq_status <= RST_IRQ;
		end else if (wr_acc && avs_address_i == IDX_IRQ_CLEAR && avs_byteenable_i[0]) begin
			irq_status <= (irq_status & ~avs_writedata_i[1:0]) | irq_events;
		end else begin
			irq_status <= irq_status | irq_events;
		end
	end

	// enable register gates status onto the level interrupt
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			irq_enable <= RST_IRQ;
		end else if (wr_acc && avs_address_i == IDX_IRQ_ENABLE && avs_byteenable_i[0]) begin
			irq_enable <= avs_writedata_i[1:0];
		end
	end

	// irq is one cycle behind status, registered for a clean pin
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_status & irq_enable);
		end
	end

	// read data mux; unmapped and write-only offsets read zero
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			avs_readdata_o <= UNMAPPED_DATA;
		end else if (rd_acc) begin
			case (avs_address_i)
				IDX_PERIOD_ONE: avs_readdata_o <= {24'h0, period_value_one};
				IDX_PERIOD_TWO: avs_readdata_o <= {24'h0, period_value_two};
				IDX_DUTY_ONE:   avs_readdata_o <= {24'h0, duty_buffer_one};
				IDX_DUTY_TWO:   avs_readdata_o <= {24'h0, duty_buffer_two};
				IDX_IRQ_STATUS: avs_readdata_o <= {30'h0, irq_status};
				IDX_IRQ_ENABLE: avs_readdata_o <= {30'h0, irq_enable};
				IDX_PWM_CTRL:   avs_readdata_o <= {24'h0, pwm_channel_control};
				IDX_TMR_CTRL:   avs_readdata_o <= {24'h0, timer_enable_prescale};
				IDX_COUNTERS:   avs_readdata_o <= {16'h0, counter_two, counter_one};
				default:        avs_readdata_o <= UNMAPPED_DATA;
			endcase
		end
	end

	// checks
	sequence s_wrap_one;
		tick_one && hit_one;
	endsequence

	AST_UPPER_ZERO: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ2]
		pwm_channel_control[7:3] == 5'h00) else $error("pwm control upper bits not zero");
	AST_TMR_WRITE: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ3]
		wr_acc && avs_address_i == IDX_TMR_CTRL && avs_byteenable_i[0]
		|=> timer_enable_prescale == $past(avs_writedata_i[7:0])) else $error("timer control write lost");
	AST_WRAP_CLEARS: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ9]
		s_wrap_one |=> counter_one == 8'h00 ##1 irq_status[0]) else $error("wrap did not clear and flag");
	AST_DUTY_LATCH: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ10]
		s_wrap_one |=> duty_latch_one == $past(duty_buffer_one)) else $error("duty not latched at wrap");
	AST_DUTY_LOW: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ10]
		tick_one && !hit_one && dhit_one |=> !raw_pwm_one) else $error("duty match did not drop output");
	AST_CASCADE_CARRY: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ7]
		cascade_select && tick_one && counter_one == 8'hff && !hit_one
		|=> counter_two == $past(counter_two) + 8'h01) else $error("upper byte missed carry");
	AST_CASCADE_HOLD: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ5]
		cascade_select && $stable(cascade_select) && !ch_tick_two |=> $stable(counter_two))
		else $error("upper byte moved without carry");
	AST_CASCADE_PIN_TWO: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ8]
		cascade_select |=> !pwm_two_o) else $error("second pin active in cascade");
	AST_SLEEP_HALT: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ12]
		sleep_i && !adc_busy_i ##1 sleep_i && !adc_busy_i |=> $stable(counter_one))
		else $error("counter ran in sleep");
	AST_FULL_MATCH: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ13]
		cascade_select && counter_one == period_value_one && counter_two != period_value_two
		|-> !hit_one) else $error("cascade match on low byte only");

	// bus handshake: a taken request is answered by exactly one low cycle
	sequence s_bus_take;
		(avs_read_i || avs_write_i) && bus_state == DTP_IDLE;
	endsequence
	sequence s_bus_answer;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence

	AST_BUS_ANSWER: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ2]
		s_bus_take |=> s_bus_answer)
		else $error("waitrequest did not drop for exactly one cycle");
	AST_PWM_WRITE: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ2]
		wr_acc && avs_address_i == IDX_PWM_CTRL && avs_byteenable_i[0]
		|=> pwm_channel_control == ($past(avs_writedata_i[7:0]) & PC_WRITE_MASK)) else $error("pwm control write lost");
	// no reset branch filter here: the check is about reset itself
	AST_PRESCALE_RESET: assert property (@(posedge core_clk_i) // [RQ11]
		srst_i |=> timer_enable_prescale == RST_TMR_CTRL)
		else $error("prescale fields survived reset");
	AST_TICK_ONLY: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ11]
		!tick_one |=> $stable(counter_one))
		else $error("counter one moved without a prescaler tick");
	// wrap behaviour of the output, built on the wrap sequence
	AST_WRAP_SETS: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ9]
		s_wrap_one ##0 (!dzero_one && pwm_channel_control[PC_CH1_EN_BIT]) |=> raw_pwm_one)
		else $error("output not set at wrap");
	AST_DUTY_ZERO: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ9]
		s_wrap_one ##0 dzero_one |=> !raw_pwm_one)
		else $error("output set with zero duty");
	AST_IRQ_LEVEL: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ9]
		|(irq_status & irq_enable) |=> irq_o)
		else $error("enabled flag did not raise irq");
	AST_FLAG_TWO_SILENT: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ8]
		cascade_select && !irq_status[1] |=> !irq_status[1])
		else $error("channel two flag set in cascade");
	AST_PIN_ONE: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ8]
		raw_pwm_one |=> pwm_one_o)
		else $error("pin one does not follow channel one");
endmodule

/* dtp_pkg.sv */
// Purpose: constants for the dual timer / pwm cascade block
// Assumes: avalon-mm slave with 32-bit data, word-indexed registers
// Notes:   byte address of a register is four times its index
package dtp_pkg;
	localparam int          ADDR_W          = 4;
	// register indices (byte address = index * 4)
	localparam logic [3:0]  IDX_PERIOD_ONE  = 4'h0;
	localparam logic [3:0]  IDX_PERIOD_TWO  = 4'h1;
	localparam logic [3:0]  IDX_DUTY_ONE    = 4'h2;
	localparam logic [3:0]  IDX_DUTY_TWO    = 4'h3;
	localparam logic [3:0]  IDX_IRQ_STATUS  = 4'h4;
	localparam logic [3:0]  IDX_IRQ_CLEAR   = 4'h5;
	localparam logic [3:0]  IDX_IRQ_ENABLE  = 4'h6;
	localparam logic [3:0]  IDX_PWM_CTRL    = 4'h7;
	localparam logic [3:0]  IDX_TMR_CTRL    = 4'h8;
	localparam logic [3:0]  IDX_COUNTERS    = 4'h9;
	// pwm_channel_control fields
	localparam int          PC_CH1_EN_BIT   = 0;
	localparam int          PC_CH2_EN_BIT   = 1;
	localparam int          PC_CASCADE_BIT  = 2;
	localparam logic [7:0]  PC_WRITE_MASK   = 8'h07;
	// timer_enable_prescale fields
	localparam int          TC_DIV1_LSB     = 0;
	localparam int          TC_DIV2_LSB     = 3;
	localparam int          TC_EN1_BIT      = 6;
	localparam int          TC_EN2_BIT      = 7;
	// reset values
	localparam logic [7:0]  RST_PWM_CTRL    = 8'h00;
	localparam logic [7:0]  RST_TMR_CTRL    = 8'h00;
	localparam logic [7:0]  RST_BYTE        = 8'h00;
	localparam logic [1:0]  RST_IRQ         = 2'h0;
	localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;
endpackage

/* dtp_prescaler.sv */
// Purpose: one prescaler producing a one-cycle tick enable
// Assumes: run gates counting; a stopped prescaler restarts from zero
// Notes:   divide codes 0..7 give 1,2,4,8,16,64,128,256
`timescale 1ns/1ps
module dtp_prescaler (
	input  wire logic       core_clk_i,
	input  wire logic       srst_i,
	input  wire logic       run_i,
	input  wire logic [2:0] div_sel_i,
	output logic            tick_o
);
	import dtp_pkg::*;
	logic [7:0] count;
	logic [7:0] limit;

	// terminal count per code; 32 is skipped on purpose
	always_comb begin
		case (div_sel_i)
			3'h0:    limit = 8'h00;
			3'h1:    limit = 8'h01;
			3'h2:    limit = 8'h03;
			3'h3:    limit = 8'h07;
			3'h4:    limit = 8'h0f;
			3'h5:    limit = 8'h3f;
			3'h6:    limit = 8'h7f;
			default: limit = 8'hff;
		endcase
	end

	// tick is registered: it is high in the cycle after the count sits at its limit
	always_ff @(posedge core_clk_i) begin
		if (srst_i || !run_i) begin
			count  <= RST_BYTE;
			tick_o <= 1'b0;
		end else if (count >= limit) begin
			count  <= RST_BYTE;
			tick_o <= 1'b1;
		end else begin
			count  <= count + 8'h01;
			tick_o <= 1'b0;
		end
	end
endmodule

/* dtp_channel.sv */
// Purpose: one 8-bit period counter with duty latch and pwm output
// Assumes: tick_i is a one-cycle enable; compare values come from outside
// Notes:   in cascade the top feeds 16-bit match results into both halves
`timescale 1ns/1ps
module dtp_channel (
	input  wire logic       core_clk_i,
	input  wire logic       srst_i,
	input  wire logic       tick_i,
	input  wire logic       period_hit_i,
	input  wire logic       duty_hit_i,
	input  wire logic       duty_zero_i,
	input  wire logic       pwm_en_i,
	input  wire logic [7:0] duty_buf_i,
	output logic [7:0]      count_o,
	output logic [7:0]      duty_latch_o,
	output logic            pwm_o,
	output logic            wrap_o
);
	import dtp_pkg::*;

	// counter wraps to zero on the tick after a period match
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			count_o <= RST_BYTE;
		end else if (tick_i) begin
			count_o <= period_hit_i ? RST_BYTE : count_o + 8'h01;
		end
	end

	// duty buffer is taken only at wrap
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			duty_latch_o <= RST_BYTE;
		end else if (tick_i && period_hit_i) begin
			duty_latch_o <= duty_buf_i;
		end
	end

	// output rises at wrap unless the new duty is zero; duty_hit_i compares the
	// coming count, so it falls on the tick that reaches duty, not one clock late
	always_ff @(posedge core_clk_i) begin
		if (srst_i || !pwm_en_i) begin
			pwm_o <= 1'b0;
		end else if (tick_i && period_hit_i) begin
			pwm_o <= !duty_zero_i;
		end else if (tick_i && duty_hit_i) begin
			pwm_o <= 1'b0;
		end
	end

	// one-cycle wrap pulse for the interrupt logic
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			wrap_o <= 1'b0;
		end else begin
			wrap_o <= tick_i && period_hit_i;
		end
	end
endmodule

/* dtp_testbench.sv */
// Purpose: self-checking bench for the dual timer / pwm cascade block
// Assumes: avalon-mm slave answers with waitrequest low one cycle after a request
// Notes:   pins are sampled on the falling edge; the bus samples on the rising edge
`timescale 1ns/1ps
module testbench;
	import dtp_pkg::*;
	typedef struct {logic [3:0] idx; logic [7:0] wd; logic [3:0] be; logic [31:0] exp;} dtp_row_t;
	logic                core_clk_i       = 1'b0;
	logic                srst_i           = 1'b1;
	logic [ADDR_W-1:0]   avs_address_i    = '0;
	logic                avs_read_i       = 1'b0;
	logic                avs_write_i      = 1'b0;
	logic [31:0]         avs_writedata_i  = '0;
	logic [3:0]          avs_byteenable_i = 4'hf;
	logic                sleep_i          = 1'b0;
	logic                adc_busy_i       = 1'b0;
	logic [31:0]         avs_readdata_o;
	logic                avs_waitrequest_o;
	logic                pwm_one_o;
	logic                pwm_two_o;
	logic                irq_o;
	int                  error_cnt        = 0;
	int                  total_checks     = 0;
	int                  cycles           = 0;
	int                  per;
	int                  hi;
	logic [31:0]         rd;
	logic [31:0]         rd2;
	dtp_row_t            rows[13];
	localparam int       DIV[8]           = '{1, 2, 4, 8, 16, 64, 128, 256};

	dtp_top dtp_top_i (
		.core_clk_i        (core_clk_i),
		.srst_i            (srst_i),
		.avs_address_i     (avs_address_i),
		.avs_read_i        (avs_read_i),
		.avs_write_i       (avs_write_i),
		.avs_writedata_i   (avs_writedata_i),
		.avs_byteenable_i  (avs_byteenable_i),
		.sleep_i           (sleep_i),
		.adc_busy_i        (adc_busy_i),
		.avs_readdata_o    (avs_readdata_o),
		.avs_waitrequest_o (avs_waitrequest_o),
		.pwm_one_o         (pwm_one_o),
		.pwm_two_o         (pwm_two_o),
		.irq_o             (irq_o)
	);

	// 250 MHz core clock
	always #2 core_clk_i = ~core_clk_i;

	// hang guard: all tests together need well under this many cycles
	always @(posedge core_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			error_cnt = error_cnt + 1;
			$display("MISMATCH timeout expected finish seen hang");
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks = total_checks + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one avalon access; request held until the edge that sees waitrequest low
	task automatic bus(input logic [3:0] idx, input logic wr, input logic [7:0] wd,
			input logic [3:0] be, output logic [31:0] data);
		int n;
		@(posedge core_clk_i);
		avs_address_i    <= idx;
		avs_write_i      <= wr;
		avs_read_i       <= ~wr;
		avs_writedata_i  <= {24'h0, wd};
		avs_byteenable_i <= be;
		n = 0;
		// waitrequest and read data are both taken at the rising edge itself
		do begin
			@(posedge core_clk_i);
			n = n + 1;
		end while (avs_waitrequest_o !== 1'b0 && n < 50);
		if (avs_waitrequest_o !== 1'b0)
			check("waitrequest", 32'h0, 32'h1);
		data = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i  <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] idx, input logic [7:0] wd);
		logic [31:0] dummy;
		bus(idx, 1'b1, wd, 4'hf, dummy);
	endtask

	task automatic rdreg(input logic [3:0] idx, output logic [31:0] data);
		bus(idx, 1'b0, 8'h00, 4'hf, data);
	endtask

	// cycles between two rising edges of a pin, and high cycles in that span
	task automatic measure(input int sel, output int p, output int h);
		logic a;
		logic b;
		int   edges;
		int   n;
		p = 0;
		h = 0;
		edges = 0;
		n = 0;
		a = sel ? pwm_two_o : pwm_one_o;
		while (edges < 2 && n < 4000) begin
			@(negedge core_clk_i);
			b = sel ? pwm_two_o : pwm_one_o;
			if (b === 1'b1 && a !== 1'b1)
				edges = edges + 1;
			if (edges == 1) begin
				p = p + 1;
				if (b === 1'b1)
					h = h + 1;
			end
			a = b;
			n = n + 1;
		end
	endtask

	// a pin that must stay low for a stretch
	task automatic quiet(input int sel, input int len);
		repeat (len) begin
			@(negedge core_clk_i);
			check(sel ? "pwm_two_o" : "pwm_one_o", 32'h0, {31'h0, sel ? pwm_two_o : pwm_one_o});
		end
	endtask

	initial begin
		rows[0]  = '{IDX_PERIOD_ONE, 8'h5a, 4'hf, 32'h5a};
		rows[1]  = '{IDX_PERIOD_TWO, 8'ha5, 4'hf, 32'ha5};
		rows[2]  = '{IDX_DUTY_ONE, 8'h3c, 4'hf, 32'h3c};
		rows[3]  = '{IDX_DUTY_TWO, 8'hc3, 4'hf, 32'hc3};
		rows[4]  = '{IDX_PWM_CTRL, 8'hff, 4'hf, 32'h07};
		rows[5]  = '{IDX_PWM_CTRL, 8'hf8, 4'hf, 32'h00};
		rows[6]  = '{IDX_TMR_CTRL, 8'h3f, 4'hf, 32'h3f};
		rows[7]  = '{IDX_TMR_CTRL, 8'h00, 4'hf, 32'h00};
		rows[8]  = '{IDX_PERIOD_ONE, 8'h11, 4'h0, 32'h5a};
		rows[9]  = '{IDX_IRQ_STATUS, 8'hff, 4'hf, 32'h00};
		rows[10] = '{4'hf, 8'h12, 4'hf, UNMAPPED_DATA};
		rows[11] = '{IDX_IRQ_ENABLE, 8'h03, 4'hf, 32'h03};
		rows[12] = '{IDX_IRQ_ENABLE, 8'h00, 4'hf, 32'h00};
		repeat (8) @(posedge core_clk_i);
		srst_i <= 1'b0;
		// every register reads zero after reset
		for (int i = 0; i <= 9; i++) begin
			rdreg(i[3:0], rd);
			check("reset value", 32'h0, rd);
		end
		check("irq_o after reset", 32'h0, {31'h0, irq_o});
		$display("test reset done");
		// register rows: write, read back
		foreach (rows[i]) begin
			bus(rows[i].idx, 1'b1, rows[i].wd, rows[i].be, rd);
			rdreg(rows[i].idx, rd);
			check("register row", rows[i].exp, rd);
		end
		$display("test register rows done");
		// channel one, all prescale codes: period (1+1)*N, high time N
		wr(IDX_PERIOD_ONE, 8'h01);
		wr(IDX_DUTY_ONE, 8'h01);
		wr(IDX_PWM_CTRL, 8'h01);
		for (int c = 0; c < 8; c++) begin
			wr(IDX_TMR_CTRL, 8'h40 | c[7:0]);
			measure(0, per, hi);
			measure(0, per, hi);
			check("ch1 period", 2 * DIV[c], per);
			check("ch1 high", DIV[c], hi);
		end
		// duty written mid-run shows at the next latch
		wr(IDX_TMR_CTRL, 8'h40);
		wr(IDX_PERIOD_ONE, 8'h07);
		wr(IDX_DUTY_ONE, 8'h03);
		measure(0, per, hi);
		measure(0, per, hi);
		check("ch1 period 8", 32'd8, per);
		check("ch1 duty 3", 32'd3, hi);
		$display("test channel one done");
		// channel two with prescale 1:2, then duty zero keeps the pin low
		wr(IDX_PERIOD_TWO, 8'h04);
		wr(IDX_DUTY_TWO, 8'h02);
		wr(IDX_TMR_CTRL, 8'hc8);
		wr(IDX_PWM_CTRL, 8'h03);
		measure(1, per, hi);
		measure(1, per, hi);
		check("ch2 period", 32'd10, per);
		check("ch2 high", 32'd4, hi);
		wr(IDX_DUTY_TWO, 8'h00);
		repeat (12) @(posedge core_clk_i);
		quiet(1, 30);
		$display("test channel two done");
		// interrupt: stop, clear, masked flag, enable, clear again
		wr(IDX_TMR_CTRL, 8'h00);
		wr(IDX_IRQ_CLEAR, 8'h03);
		rdreg(IDX_IRQ_STATUS, rd);
		check("status cleared", 32'h0, rd);
		wr(IDX_TMR_CTRL, 8'h40);
		repeat (20) @(posedge core_clk_i);
		wr(IDX_TMR_CTRL, 8'h00);
		rdreg(IDX_IRQ_STATUS, rd);
		check("ch1 flag", 32'h1, rd);
		check("irq masked", 32'h0, {31'h0, irq_o});
		wr(IDX_IRQ_ENABLE, 8'h01);
		repeat (3) @(negedge core_clk_i);
		check("irq raised", 32'h1, {31'h0, irq_o});
		wr(IDX_IRQ_CLEAR, 8'h01);
		repeat (3) @(negedge core_clk_i);
		check("irq cleared", 32'h0, {31'h0, irq_o});
		$display("test interrupt done");
		// sleep halts the counters unless a conversion runs
		wr(IDX_PERIOD_ONE, 8'hff);
		wr(IDX_PWM_CTRL, 8'h00);
		wr(IDX_TMR_CTRL, 8'h40);
		@(posedge core_clk_i);
		sleep_i <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		rdreg(IDX_COUNTERS, rd);
		rdreg(IDX_COUNTERS, rd2);
		check("counters in sleep", rd, rd2);
		@(posedge core_clk_i);
		adc_busy_i <= 1'b1;
		rdreg(IDX_COUNTERS, rd);
		rdreg(IDX_COUNTERS, rd2);
		check("counters during conversion", 32'h1, {31'h0, rd !== rd2});
		@(posedge core_clk_i);
		sleep_i    <= 1'b0;
		adc_busy_i <= 1'b0;
		$display("test sleep done");
		// reset in mid-run; also gives cascade clean counters below its period
		@(posedge core_clk_i);
		srst_i <= 1'b1;
		repeat (8) @(posedge core_clk_i);
		srst_i <= 1'b0;
		@(negedge core_clk_i);
		check("waitrequest in reset", 32'h1, {31'h0, avs_waitrequest_o});
		check("irq_o in reset", 32'h0, {31'h0, irq_o});
		rdreg(IDX_TMR_CTRL, rd);
		check("prescale after reset", 32'h0, rd);
		rdreg(IDX_COUNTERS, rd);
		check("counters after reset", 32'h0, rd);
		$display("test mid-run reset done");
		// cascade: 16-bit period 0x0103, duty 0x0080, channel one prescaler
		wr(IDX_TMR_CTRL, 8'h00);
		wr(IDX_IRQ_CLEAR, 8'h03);
		wr(IDX_PERIOD_ONE, 8'h03);
		wr(IDX_PERIOD_TWO, 8'h01);
		wr(IDX_DUTY_ONE, 8'h80);
		wr(IDX_DUTY_TWO, 8'h00);
		wr(IDX_PWM_CTRL, 8'h07);
		wr(IDX_TMR_CTRL, 8'h78);
		measure(0, per, hi);
		measure(0, per, hi);
		check("cascade period", 32'd260, per);
		check("cascade high", 32'd128, hi);
		quiet(1, 20);
		rdreg(IDX_IRQ_STATUS, rd);
		check("cascade flag", 32'h1, rd);
		$display("test cascade done");
		print_verdict();
	end
endmodule
